// File: clc_cell.sv
// Operation
// - Two independent sixteen-entry four-input tables
// - Three-input combining table, one direct input
// - Two combining inputs steered: table or control
// - Three tables together give any five-input function
// - Two storage outputs; both function outputs are registered too
// - Storage data from four-way source selector
// - Each output picks own table or combiner
// - Direct data or combiner output reaches storage
// - Shared clock, enable, preset/clear, global init
// - Per-element clock edge inversion
// - Enable active high, synchronous, unconnected means on
// - Preset/clear asynchronous, high, forces configured value
// - Power-up and global init load configured value
// - Unused preset/clear stays inactive
// - Optional latch: follows while clock low, or while high if inverted
// - Any control input drives any internal control
// - Preset, direct, combine-one double as inputs 0,2,1
`default_nettype none

module clc_cell
  import clc_pkg::*;
(
  input wire logic sys_clk,                     // System clock, 10 MHz
  input wire logic rst_b,                       // Async power-up reset, active low
  input wire logic cfg_load,                    // Configuration load window, high
  input wire clc_cfg_t cfg_in,                  // Configuration image
  input wire logic [3:0] first_table_inputs,    // First table inputs
  input wire logic [3:0] second_table_inputs,   // Second table inputs
  input wire logic [3:0] control_inputs,        // General control inputs
  input wire logic storage_timing_edge,         // Shared cell clock
  input wire logic global_init,                 // Global initialisation, high
  output logic comb_out_x,                      // First combinational output
  output logic comb_out_y,                      // Second combinational output
  output logic [1:0] store_q,                   // Storage element outputs
  output logic cell_ready                       // Configured and running
);

  clc_state_t st;
  clc_state_t next_st;
  clc_ctrl_t ctrl;
  logic out_first;
  logic out_second;
  logic out_combine;
  logic [2:0] combine_idx;
  logic [1:0] store_d;
  logic init_now;
  logic running;

  // Table lookup, shared by both four-input tables
  function automatic logic lut4_eval(input logic [15:0] table_bits, input logic [3:0] sel);
    lut4_eval = table_bits[sel];
  endfunction

  function automatic logic lut3_eval(input logic [7:0] table_bits, input logic [2:0] sel);
    lut3_eval = table_bits[sel];
  endfunction

  // Control steering, one selector per internal control
  function automatic logic ctrl_pick(input logic [3:0] src, input logic [1:0] sel);
    ctrl_pick = src[sel];
  endfunction

  // Four-way storage source choice
  function automatic logic data_pick(
    input logic [1:0] sel,
    input logic f,
    input logic g,
    input logic h,
    input logic din
  );
    logic r;
    r = f;
    unique case (sel)
      CLC_DSRC_FIRST: r = f;
      CLC_DSRC_SECOND: r = g;
      CLC_DSRC_COMBINE: r = h;
      CLC_DSRC_DIRECT: r = din;
    endcase
    data_pick = r;
  endfunction

  // Internal controls from synchronised control inputs
  always_comb begin
    ctrl.store_enable = ctrl_pick(st.sync2.control_inputs, st.cfg.ce_pick);
    ctrl.async_preset_clear = ctrl_pick(st.sync2.control_inputs, st.cfg.preset_pick);
    ctrl.direct_data = ctrl_pick(st.sync2.control_inputs, st.cfg.direct_pick);
    ctrl.combine_input_one = ctrl_pick(st.sync2.control_inputs, st.cfg.h1_pick);
  end

  // Function generators
  always_comb begin
    out_first = lut4_eval(st.cfg.lut_first, st.sync2.first_table_inputs);
    out_second = lut4_eval(st.cfg.lut_second, st.sync2.second_table_inputs);
    combine_idx[0] = (st.cfg.h0_sel == CLC_H0_FROM_SECOND) ? out_second
                   : ctrl.async_preset_clear;
    combine_idx[1] = ctrl.combine_input_one;
    combine_idx[2] = (st.cfg.h2_sel == CLC_H2_FROM_FIRST) ? out_first
                   : ctrl.direct_data;
    out_combine = lut3_eval(st.cfg.lut_combine, combine_idx);
  end

  // Storage data selection
  always_comb begin
    for (int i = 0; i < CLC_NUM_ELEM; i++) begin
      store_d[i] = data_pick(st.cfg.elem[i].data_sel, out_first, out_second,
                             out_combine, ctrl.direct_data);
    end
  end

  // Global init acts in the running phase; the start phase covers power-up
  always_comb begin
    running = (st.phase == CLC_PH_RUN);
    init_now = (st.phase == CLC_PH_START) || (running && st.sync2.global_init);
  end

  // Phase sequencing and configuration capture
  always_comb begin
    next_st = st;
    // Two-stage capture of every table, control, clock and init input; first stage feeds only the second
    next_st.sync1.first_table_inputs = first_table_inputs;
    next_st.sync1.second_table_inputs = second_table_inputs;
    next_st.sync1.control_inputs = control_inputs;
    next_st.sync1.storage_timing_edge = storage_timing_edge;
    next_st.sync1.global_init = global_init;
    next_st.sync2 = st.sync1;
    next_st.clk_prev = st.sync2.storage_timing_edge;
    unique case (st.phase)
      CLC_PH_IDLE: begin
        if (cfg_load) begin
          next_st.phase = CLC_PH_LOAD;
        end
      end
      CLC_PH_LOAD: begin
        next_st.cfg = cfg_in;
        if (!cfg_load) begin
          next_st.phase = CLC_PH_START;
        end
      end
      CLC_PH_START: begin
        next_st.phase = CLC_PH_RUN;
      end
      CLC_PH_RUN: begin
        // Configuration stays frozen until the next power-up
        next_st.phase = CLC_PH_RUN;
      end
    endcase
    next_st.ready = (next_st.phase == CLC_PH_RUN);
    // each output own table or combiner
    next_st.comb_x = (st.cfg.x_sel == CLC_OUT_FROM_COMBINE) ? out_combine : out_first;
    next_st.comb_y = (st.cfg.y_sel == CLC_OUT_FROM_COMBINE) ? out_combine : out_second;
    if (!running) begin
      next_st.comb_x = CLC_RST_BIT;
      next_st.comb_y = CLC_RST_BIT;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  for (genvar e = 0; e < CLC_NUM_ELEM; e++) begin : g_store
    clc_store u_store (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ecfg(st.cfg.elem[e]),
      .init_now(init_now),
      .run(running),
      .cell_clk(st.sync2.storage_timing_edge),
      .cell_clk_prev(st.clk_prev),
      .ce(ctrl.store_enable),
      .sr(ctrl.async_preset_clear),
      .d(store_d[e]),
      .q(store_q[e])
    );
  end

  assign comb_out_x = st.comb_x;
  assign comb_out_y = st.comb_y;
  assign cell_ready = st.ready;

endmodule

`default_nettype wire

// File: clc_pkg.sv
`default_nettype none

package clc_pkg;

  // Table geometry
  localparam int CLC_LUT4_IN = 4;
  localparam int CLC_LUT4_SIZE = 16;
  localparam int CLC_LUT3_IN = 3;
  localparam int CLC_LUT3_SIZE = 8;
  localparam int CLC_NUM_CTRL = 4;
  localparam int CLC_NUM_ELEM = 2;

  // Storage data source codes
  localparam logic [1:0] CLC_DSRC_FIRST = 2'h0;
  localparam logic [1:0] CLC_DSRC_SECOND = 2'h1;
  localparam logic [1:0] CLC_DSRC_COMBINE = 2'h2;
  localparam logic [1:0] CLC_DSRC_DIRECT = 2'h3;

  // Combining-table input steering
  localparam logic CLC_H0_FROM_PRESET = 1'h0;
  localparam logic CLC_H0_FROM_SECOND = 1'h1;
  localparam logic CLC_H2_FROM_DIRECT = 1'h0;
  localparam logic CLC_H2_FROM_FIRST = 1'h1;

  // Combinational output steering
  localparam logic CLC_OUT_FROM_TABLE = 1'h0;
  localparam logic CLC_OUT_FROM_COMBINE = 1'h1;

  // Set/reset polarity of a storage element
  localparam logic CLC_INIT_RESET = 1'h0;
  localparam logic CLC_INIT_SET = 1'h1;

  // Latch mode exists only on the low-voltage variant
  localparam logic CLC_LATCH_CAPABLE = 1'h1;

  // Reset values
  localparam logic CLC_RST_BIT = 1'h0;
  localparam logic [15:0] CLC_LUT4_RST = 16'h0000;
  localparam logic [7:0] CLC_LUT3_RST = 8'h00;
  localparam logic [1:0] CLC_PICK_RST = 2'h0;

  typedef enum logic [1:0] {
    CLC_PH_IDLE = 2'b00,
    CLC_PH_LOAD = 2'b01,
    CLC_PH_START = 2'b11,
    CLC_PH_RUN = 2'b10
  } clc_phase_t;

  typedef struct packed {
    logic ce_used;
    logic sr_used;
    logic sr_is_set;
    logic clk_invert;
    logic latch_mode;
    logic [1:0] data_sel;
  } clc_elem_cfg_t;

  typedef struct packed {
    logic [15:0] lut_first;
    logic [15:0] lut_second;
    logic [7:0] lut_combine;
    logic h0_sel;
    logic h2_sel;
    logic x_sel;
    logic y_sel;
    logic [1:0] ce_pick;
    logic [1:0] preset_pick;
    logic [1:0] direct_pick;
    logic [1:0] h1_pick;
    clc_elem_cfg_t [1:0] elem;
  } clc_cfg_t;

  typedef struct packed {
    logic [3:0] first_table_inputs;
    logic [3:0] second_table_inputs;
    logic [3:0] control_inputs;
    logic storage_timing_edge;
    logic global_init;
  } clc_pins_t;

  typedef struct packed {
    logic store_enable;
    logic async_preset_clear;
    logic direct_data;
    logic combine_input_one;
  } clc_ctrl_t;

  typedef struct packed {
    clc_phase_t phase;
    clc_cfg_t cfg;
    clc_pins_t sync1;
    clc_pins_t sync2;
    logic clk_prev;
    logic comb_x;
    logic comb_y;
    logic ready;
  } clc_state_t;

  typedef struct packed {
    logic q;
  } clc_store_state_t;

endpackage

`default_nettype wire

// File: clc_store.sv
`default_nettype none

module clc_store
  import clc_pkg::*;
(
  input wire logic sys_clk,           // System clock
  input wire logic rst_b,             // Async reset, active low
  input wire clc_elem_cfg_t ecfg,     // Static element configuration
  input wire logic init_now,          // Load configured init value
  input wire logic run,               // Cell is operational
  input wire logic cell_clk,          // Synchronised cell clock level
  input wire logic cell_clk_prev,     // Cell clock level one cycle back
  input wire logic ce,                // Internal store enable
  input wire logic sr,                // Internal async preset/clear
  input wire logic d,                 // Selected data
  output logic q                      // Stored value
);

  clc_store_state_t st;
  clc_store_state_t next_st;

  always_comb begin
    logic rise;
    logic fall;
    logic trig;
    logic transparent;
    logic en;
    rise = 1'h0;
    fall = 1'h0;
    trig = 1'h0;
    transparent = 1'h0;
    en = 1'h0;
    next_st = st;
    rise = cell_clk & ~cell_clk_prev;
    fall = ~cell_clk & cell_clk_prev;
    trig = ecfg.clk_invert ? fall : rise;
    transparent = ecfg.clk_invert ? cell_clk : ~cell_clk;
    en = ecfg.ce_used ? ce : 1'h1;
    if (init_now) begin
      next_st.q = ecfg.sr_is_set;
    end else if (run) begin
      if (ecfg.sr_used && sr) begin
        next_st.q = ecfg.sr_is_set;
      end else if (en) begin
        if (CLC_LATCH_CAPABLE && ecfg.latch_mode) begin
          if (transparent) begin
            next_st.q = d;
          end
        end else if (trig) begin
          next_st.q = d;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule

`default_nettype wire

// File: clc_cell_monitor.sv
`default_nettype none

module clc_cell_monitor
  import clc_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic cfg_load, // Load window
  input wire clc_cfg_t cfg_in, // Config image
  input wire logic [3:0] first_table_inputs, // First table
  input wire logic [3:0] second_table_inputs, // Second table
  input wire logic [3:0] control_inputs, // Controls
  input wire logic storage_timing_edge, // Cell clock
  input wire logic global_init, // Global init
  input wire logic comb_out_x, // X output
  input wire logic comb_out_y, // Y output
  input wire logic [1:0] store_q, // Storage outputs
  input wire logic cell_ready // Running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic en = control_inputs[cfg_in.ce_pick];
  wire logic pre = control_inputs[cfg_in.preset_pick];
  wire logic [1:0] init = {cfg_in.elem[1].sr_is_set, cfg_in.elem[0].sr_is_set};

  chk_ready_after_load: assert property ($fell(cfg_load) |-> ##[1:3] cell_ready)
    else $error("cell not ready after load");
  chk_ready_stays: assert property (cell_ready |=> cell_ready)
    else $error("ready dropped");
  chk_init_value: assert property ($rose(cell_ready) |-> store_q == init)
    else $error("wrong start value");
  chk_x_first: assert property (cell_ready && $past(cell_ready, 4) && !cfg_in.x_sel
    |-> comb_out_x == cfg_in.lut_first[$past(first_table_inputs, 3)])
    else $error("x output wrong");
  chk_y_second: assert property (cell_ready && $past(cell_ready, 4) && !cfg_in.y_sel
    |-> comb_out_y == cfg_in.lut_second[$past(second_table_inputs, 3)])
    else $error("y output wrong");
  chk_global_init: assert property ((global_init && cell_ready)[*4] |-> store_q == init)
    else $error("global init ignored");
  chk_preset_force: assert property ((cell_ready && pre && cfg_in.elem[0].sr_used)[*4]
    |-> store_q[0] == cfg_in.elem[0].sr_is_set)
    else $error("preset not forced");
  chk_enable_hold: assert property ((cell_ready && !en && !pre && !global_init
    && cfg_in.elem[0].ce_used && !cfg_in.elem[0].latch_mode)[*5] |-> $stable(store_q[0]))
    else $error("store moved with enable low");

  cover property ($rose(cell_ready));
  cover property (cell_ready && global_init);
  cover property (cell_ready && $rose(storage_timing_edge));
endmodule

bind clc_cell clc_cell_monitor u_mon (.sys_clk, .rst_b, .cfg_load, .cfg_in,
  .first_table_inputs, .second_table_inputs, .control_inputs, .storage_timing_edge,
  .global_init, .comb_out_x, .comb_out_y, .store_q, .cell_ready);

`default_nettype wire

// File: clc_route_model.sv
`default_nettype none

module clc_route_model
  import clc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Reset, low
  input wire logic level_req, // Wanted cell clock level
  output logic cell_clk // Cell clock to the cell
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold;

  // Each level stands four cycles at least, so the cell never misses a pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cell_clk <= 1'h0;
      hold <= 2'h0;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (level_req != cell_clk) begin
      cell_clk <= level_req;
      hold <= 2'h3;
    end
  end
endmodule

`default_nettype wire

// File: tb_configurable_logic_cell.sv
`default_nettype none

module tb_configurable_logic_cell import clc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_b, cfg_load, global_init, level_req, cell_clk;
  logic comb_out_x, comb_out_y, cell_ready;
  logic [1:0] store_q;
  logic [3:0] fti, sti, ci;
  logic [2:0] m;
  clc_cfg_t cfg;
  int failures, compares, cycles;

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  clc_route_model partner (.sys_clk(sys_clk), .rst_b(rst_b), .level_req(level_req),
    .cell_clk(cell_clk));
  clc_cell dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_load(cfg_load), .cfg_in(cfg),
    .first_table_inputs(fti), .second_table_inputs(sti), .control_inputs(ci),
    .storage_timing_edge(cell_clk), .global_init(global_init), .comb_out_x(comb_out_x),
    .comb_out_y(comb_out_y), .store_q(store_q), .cell_ready(cell_ready));

  // Returns combiner, second and first table values
  function automatic logic [2:0] mdl(logic [3:0] f, logic [3:0] g, logic [3:0] c);
    logic fv, gv, i0, i2;
    fv = cfg.lut_first[f];
    gv = cfg.lut_second[g];
    i0 = cfg.h0_sel ? gv : c[cfg.preset_pick];
    i2 = cfg.h2_sel ? fv : c[cfg.direct_pick];
    return {cfg.lut_combine[{i2, c[cfg.h1_pick], i0}], gv, fv};
  endfunction

  task automatic check(logic [1:0] seen, logic [1:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Sync plus output register take three edges; eight leaves margin
  task automatic drive(logic [3:0] f, logic [3:0] g, logic [3:0] c);
    @(posedge sys_clk);
    fti <= f;
    sti <= g;
    ci <= c;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    m = mdl(f, g, c);
  endtask

  task automatic clk_to(logic v);
    @(posedge sys_clk);
    level_req <= v;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic boot(clc_cfg_t c);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    cfg <= c;
    level_req <= 1'h0;
    ci <= 4'h0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    check({comb_out_x, comb_out_y}, 2'h0);
    check(store_q, 2'h0);
    @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    cfg_load <= 1'h1;
    repeat (2) @(posedge sys_clk);
    cfg_load <= 1'h0;
    for (int i = 0; i < 10 && cell_ready !== 1'h1; i++) @(posedge sys_clk);
    @(negedge sys_clk);
    check({1'h0, cell_ready}, 2'h1);
    check(store_q, {c.elem[1].sr_is_set, c.elem[0].sr_is_set});
  endtask

  task automatic sweep();
    for (int i = 0; i < 16; i++) begin
      drive(4'(i), 4'(15 - i), 4'(i * 7));
      check({comb_out_x, comb_out_y}, {cfg.x_sel ? m[2] : m[0], cfg.y_sel ? m[2] : m[1]});
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {rst_b, cfg_load, global_init, level_req} = 4'h0;
    {fti, sti, ci} = 12'h000;
    cfg = '0;
    // Edge elements: first reset on direct data, second set, inverted, on combiner
    boot(clc_cfg_t'({16'h8000, 16'h6996, 8'hb4, 4'hd, 8'h1b, 7'h7a, 7'h63}));
    sweep();
    drive(4'h0, 4'h0, 4'h5);
    clk_to(1'h1);
    check(store_q, 2'b11);
    drive(4'h0, 4'h3, 4'h5);
    clk_to(1'h0);
    check(store_q, {m[2], 1'h1});
    drive(4'hf, 4'h0, 4'h4);
    clk_to(1'h1);
    clk_to(1'h0);
    check(store_q, 2'b01);
    drive(4'h0, 4'h0, 4'h2);
    check(store_q, 2'b10);
    // Latch on first table, edge element without enable on second table
    boot(clc_cfg_t'({16'hf0a5, 16'h3c01, 8'h6e, 4'h2, 8'he4, 7'h21, 7'h44}));
    sweep();
    drive(4'h0, 4'h0, 4'h8);
    check({1'h0, store_q[0]}, {1'h0, m[0]});
    clk_to(1'h1);
    drive(4'h4, 4'h0, 4'h8);
    check(store_q, 2'b11);
    drive(4'h4, 4'h1, 4'h0);
    clk_to(1'h0);
    clk_to(1'h1);
    check(store_q, 2'b01);
    drive(4'h4, 4'h1, 4'h4);
    check(store_q, 2'b01);
    // Stored value differs from the init value here, so the pulse must be seen
    @(posedge sys_clk);
    global_init <= 1'h1;
    drive(4'h0, 4'h0, 4'h0);
    @(posedge sys_clk);
    global_init <= 1'h0;
    @(negedge sys_clk);
    check(store_q, 2'b00);
    conclude();
  end
endmodule

`default_nettype wire
